// *** hdl/fmsc_cfg.svh ***
// fmsc_cfg.svh: constants for the fet mux switch control block
`ifndef FMSC_CFG_SVH
`define FMSC_CFG_SVH
`define FMSC_BANK_CH_MAX   40
`define FMSC_PAIR_OFFSET   20
`define FMSC_CH_W          6
`define FMSC_NUM_REL       4
`define FMSC_REL_BANK_BIT  1
`define FMSC_SYNC_RST      1'b0
`define FMSC_TYPE_DIFF     8'h5a
`define FMSC_TYPE_SINGLE   8'ha5
`define FMSC_NO_CH         6'h3f
`endif

// *** hdl/fmsc_pkg.sv ***
// fmsc_pkg.sv: types for the fet mux switch control block
`include "fmsc_cfg.svh"
package fmsc_pkg;
  typedef enum logic [1:0] {
    FMSC_WIRE_TWO    = 2'b00,
    FMSC_WIRE_FOUR   = 2'b01,
    FMSC_WIRE_ONE    = 2'b10
  } fmsc_wire_t;

  typedef enum logic [2:0] {
    FMSC_OP_NONE     = 3'b000,
    FMSC_OP_CLOSE    = 3'b001,
    FMSC_OP_OPEN     = 3'b010,
    FMSC_OP_REL_CLS  = 3'b011,
    FMSC_OP_REL_OPN  = 3'b100,
    FMSC_OP_OPEN_ALL = 3'b101
  } fmsc_op_t;

  typedef struct packed {
    fmsc_op_t                 op;
    logic                     bank;
    logic [`FMSC_CH_W-1:0]    chan;
    logic [1:0]               rel;
    logic                     four_wire;
  } fmsc_cmd_t;

  typedef struct packed {
    logic                     done;
    logic                     err;
  } fmsc_resp_t;
endpackage : fmsc_pkg

// *** hdl/fmsc_sync.sv ***
// fmsc_sync.sv: two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module fmsc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // fmsc_sync
`default_nettype wire

// *** hdl/fmsc_top.sv ***
// fmsc_top.sv: switch, relay, mode, interlock and overvoltage control
//
// Overview of operation
// R1: with module power absent every switch and relay output is held open
// R2: four bus relays route either bank onto the two measurement buses
// R3: each channel opens or closes on command; wiring mode is set by command
// R4: two-wire mode gives each bank its own twenty-channel mux
// R5: forty-channel two-wire operation only via bus relays or outside wiring
// R6: four-wire mode closes bank one channel n with channel n plus 20
// R7: pairing happens only for four-wire measure or four-wire scanned channels
// R8: one-wire mode gives each bank its own forty-channel single-ended mux
// R9: eighty-channel one-wire operation only via bus relays or outside wiring
// R10: switching between one-wire and differential modes waits for power cycle
// R11: module type answer reflects the configured wiring mode
// R12: broken interlock opens that bank's bus relays at once
// R13: outside wiring must short each bank's interlock before relays close
// R14: overvoltage opens all relays and switches and latches the fault state
// R15: closures during overvoltage are refused with an error status
// R16: slot clear ends the overvoltage state of this module only
// R17: global reset or power cycle restores defaults and clears overvoltage; a power cycle applies the pending mode, not the default two-wire
// R18: persisting overvoltage at clear re-enters the fault state at once
// R19: at most one channel closed per bank at any time
// R20: terminal block mismatch with wiring mode raises no error
// R21: relay close with open interlock is refused; relay held open meanwhile
`timescale 1ns/1ns
`default_nettype none
module fmsc_top
  import fmsc_pkg::*;
#(
  parameter int CH_W = `FMSC_CH_W
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  input  wire logic                    power_good,
  input  wire logic                    global_reset_cmd,
  input  wire logic                    slot_clear_cmd,
  input  wire logic                    module_type_query,
  input  wire logic                    four_wire_ohms_measure,
  input  wire logic                    mode_set_valid,
  input  wire fmsc_pkg::fmsc_wire_t    mode_set,
  input  wire logic                    cmd_valid,
  input  wire fmsc_pkg::fmsc_cmd_t     cmd,
  input  wire logic [1:0]              interlock_ok_pin,
  input  wire logic                    overvolt_pin,
  output var  fmsc_pkg::fmsc_resp_t    resp,
  output var  logic                    type_valid,
  output var  logic [7:0]              type_code,
  output var  fmsc_pkg::fmsc_wire_t    active_mode,
  output var  logic                    overvolt_state,
  output var  logic [CH_W-1:0]         bank_one_sel,
  output var  logic                    bank_one_on,
  output var  logic [CH_W-1:0]         bank_two_sel,
  output var  logic                    bank_two_on,
  output var  logic [`FMSC_NUM_REL-1:0] bus_relay_on
);
  import fmsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] ilk_s;
  logic       ov_s;
  logic       pwr_s;

  // interlock, overvoltage and power sense all come from outside the clock
  fmsc_sync #(.W(4)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({interlock_ok_pin, overvolt_pin, power_good}),
    .q       ({ilk_s, ov_s, pwr_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    fmsc_wire_t             mode;      // mode in force
    fmsc_wire_t             pend;      // mode waiting for a power cycle
    logic                   pwr_prev;
    logic                   ov;
    logic [CH_W-1:0]        sel1;
    logic                   on1;
    logic [CH_W-1:0]        sel2;
    logic                   on2;
    logic                   pair;      // bank two closed as a four-wire partner
    logic [`FMSC_NUM_REL-1:0] rel;
    fmsc_resp_t             resp;
    logic                   tv;
    logic [7:0]             tc;
  } fmsc_state_t;

  fmsc_state_t s_q;
  fmsc_state_t s_d;

  // relays 0,1 belong to bank one and 2,3 to bank two
  function automatic logic rel_bank(input logic [1:0] r);
    rel_bank = r[`FMSC_REL_BANK_BIT];
  endfunction

  // channel count per bank depends on the mode in force
  function automatic logic ch_legal(input fmsc_wire_t m, input logic [CH_W-1:0] c);
    if (m == FMSC_WIRE_ONE) begin
      ch_legal = c < CH_W'(`FMSC_BANK_CH_MAX);
    end else begin
      ch_legal = c < CH_W'(`FMSC_PAIR_OFFSET);
    end
  endfunction

  // relays of a bank allowed only with its interlock closed
  function automatic logic [`FMSC_NUM_REL-1:0] ilk_mask(input logic [1:0] ilk);
    ilk_mask = {{2{ilk[1]}}, {2{ilk[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic         pwr_up;
    logic         four_ok;
    s_d           = s_q;
    pwr_up        = pwr_s & ~s_q.pwr_prev;
    four_ok       = 1'b0;
    s_d.pwr_prev  = pwr_s;
    s_d.resp      = '0;
    s_d.tv        = 1'b0;

    if (!pwr_s || global_reset_cmd) begin
      // no power or global reset: everything open, fault cleared; only global reset restores default modes
      s_d.sel1 = '0;                                                      // R1
      s_d.on1  = 1'b0;                                                    // R1
      s_d.sel2 = '0;
      s_d.on2  = 1'b0;
      s_d.pair = 1'b0;
      s_d.rel  = '0;                                                      // R1
      s_d.ov   = 1'b0;                                                    // R17
      if (global_reset_cmd) begin
        s_d.mode = FMSC_WIRE_TWO;                                         // R17
        s_d.pend = FMSC_WIRE_TWO;
      end
    end else begin
      if (pwr_up) begin
        s_d.mode = s_q.pend;                                              // R10
      end

      // mode command: a cross between one-wire and differential waits
      if (mode_set_valid) begin
        s_d.pend = mode_set;                                              // R3
        if ((mode_set == FMSC_WIRE_ONE) == (s_q.mode == FMSC_WIRE_ONE)) begin
          s_d.mode = mode_set;
        end                                                               // R10
      end

      // slot clear ends only this module's fault; a live fault re-latches below
      if (slot_clear_cmd) begin
        s_d.ov = 1'b0;                                                    // R16
      end

      // switch and relay commands
      if (cmd_valid) begin
        s_d.resp.done = 1'b1;
        unique case (cmd.op)
          FMSC_OP_NONE: begin
            s_d.resp.done = 1'b0;
          end
          FMSC_OP_CLOSE: begin
            four_ok = cmd.four_wire || four_wire_ohms_measure;            // R7
            if (s_q.ov) begin
              s_d.resp.err = 1'b1;                                        // R15
            end else if (!ch_legal(s_q.mode, cmd.chan)) begin
              s_d.resp.err = 1'b1;
            end else if (s_q.mode == FMSC_WIRE_FOUR && four_ok) begin
              // pair channel n with its partner n+20 in bank two
              s_d.sel1 = cmd.chan;                                        // R6
              s_d.on1  = 1'b1;
              s_d.sel2 = cmd.chan;                                        // R6
              s_d.on2  = 1'b1;
              s_d.pair = 1'b1;
            end else if (!cmd.bank) begin
              s_d.sel1 = cmd.chan;                                        // R19
              s_d.on1  = 1'b1;                                            // R3 R4 R8
              if (s_q.pair) begin
                s_d.on2  = 1'b0;
                s_d.pair = 1'b0;
              end
            end else begin
              s_d.sel2 = cmd.chan;                                        // R19
              s_d.on2  = 1'b1;                                            // R4 R8
              s_d.pair = 1'b0;
              if (s_q.pair) begin
                s_d.on1 = 1'b0;
              end
            end
          end
          FMSC_OP_OPEN: begin
            if (!cmd.bank || s_q.pair) begin
              s_d.on1 = 1'b0;                                             // R3
            end
            if (cmd.bank || s_q.pair) begin
              s_d.on2 = 1'b0;
            end
            s_d.pair = 1'b0;
          end
          FMSC_OP_REL_CLS: begin
            // combining banks is only ever through these relays
            if (s_q.ov) begin
              s_d.resp.err = 1'b1;                                        // R15
            end else if (!ilk_s[rel_bank(cmd.rel)]) begin
              s_d.resp.err = 1'b1;                                        // R21
            end else begin
              s_d.rel[cmd.rel] = 1'b1;                                    // R2 R5 R9
            end
          end
          FMSC_OP_REL_OPN: begin
            s_d.rel[cmd.rel] = 1'b0;
          end
          FMSC_OP_OPEN_ALL: begin
            s_d.on1  = 1'b0;
            s_d.on2  = 1'b0;
            s_d.pair = 1'b0;
            s_d.rel  = '0;
          end
          default: begin
            s_d.resp.err = 1'b1;                                          // illegal op code
          end
        endcase
      end

      // broken interlock drops that bank's relays regardless of command
      s_d.rel = s_d.rel & ilk_mask(ilk_s);                                // R12 R13 R21

      // a live fault wins over clear and over any closure this cycle
      if (ov_s) begin
        s_d.ov = 1'b1;                                                    // R14 R18
      end
      if (s_d.ov) begin
        s_d.on1  = 1'b0;                                                  // R14
        s_d.on2  = 1'b0;
        s_d.pair = 1'b0;
        s_d.rel  = '0;                                                    // R14
      end

      // type answer tracks the mode in force; terminal block never checked
      if (module_type_query) begin
        s_d.tv = 1'b1;                                                    // R11 R20
        s_d.tc = (s_d.mode == FMSC_WIRE_ONE) ? `FMSC_TYPE_SINGLE : `FMSC_TYPE_DIFF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; clock enable freezes everything
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{mode: FMSC_WIRE_TWO, pend: FMSC_WIRE_TWO, pwr_prev: `FMSC_SYNC_RST,
               default: '0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  assign resp           = s_q.resp;
  assign type_valid     = s_q.tv;
  assign type_code      = s_q.tc;
  assign active_mode    = s_q.mode;
  assign overvolt_state = s_q.ov;
  assign bank_one_sel   = s_q.sel1;
  assign bank_one_on    = s_q.on1;
  assign bank_two_sel   = s_q.sel2;  // in four-wire pairing this means channel sel+20
  assign bank_two_on    = s_q.on2;
  assign bus_relay_on   = s_q.rel;
endmodule // fmsc_top
`default_nettype wire

// *** sim/fmsc_chk_sva.sv ***
// fmsc_chk_sva.sv: concurrent checks on the switch control block ports
`timescale 1ns/1ns
`default_nettype none
`include "fmsc_cfg.svh"
module fmsc_chk #(
  parameter int CH_W = 6
) (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic                    power_good,
  input wire logic                    module_type_query,
  input wire logic                    cmd_valid,
  input wire fmsc_pkg::fmsc_cmd_t     cmd,
  input wire logic [1:0]              interlock_ok_pin,
  input wire logic                    overvolt_pin,
  input wire fmsc_pkg::fmsc_resp_t    resp,
  input wire logic                    type_valid,
  input wire logic [7:0]              type_code,
  input wire fmsc_pkg::fmsc_wire_t    active_mode,
  input wire logic                    overvolt_state,
  input wire logic [CH_W-1:0]         bank_one_sel,
  input wire logic                    bank_one_on,
  input wire logic [CH_W-1:0]         bank_two_sel,
  input wire logic                    bank_two_on,
  input wire logic [`FMSC_NUM_REL-1:0] bus_relay_on
);
  import fmsc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // power must be seen on two edges first, the pin crosses two flops
  logic [1:0] pg_cnt_q;
  logic       take;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) pg_cnt_q <= 2'h0;
    else if (!power_good) pg_cnt_q <= 2'h0;
    else if (!pg_cnt_q[1]) pg_cnt_q <= pg_cnt_q + 2'h1;
  end
  assign take = cmd_valid && power_good && pg_cnt_q[1];
  ////////////////////////////////////////////////////////////
  // pin events get five samples: two sync flops plus the state register
  a_power_off_open: assert property ((!power_good) [*5] |-> !bank_one_on && !bank_two_on && bus_relay_on == '0)
    else $error("switch closed while power absent");
  a_ov_all_open: assert property (overvolt_state |-> !bank_one_on && !bank_two_on && bus_relay_on == '0)
    else $error("switch closed in overvoltage");
  a_ov_latch: assert property ((overvolt_pin && power_good) [*5] |-> overvolt_state)
    else $error("overvoltage not held");
  a_ov_refuse: assert property (take && overvolt_state && cmd.op == FMSC_OP_CLOSE |=> resp.err)
    else $error("close accepted in overvoltage");
  a_cmd_answer: assert property (take |=> resp.done)
    else $error("command not answered");
  a_resp_cause: assert property (resp.done |-> $past(take))
    else $error("answer without command");
  a_close_sel: assert property (take && cmd.op == FMSC_OP_CLOSE && !cmd.bank ##1 !resp.err
    |-> bank_one_on && bank_one_sel == $past(cmd.chan))
    else $error("bank one selection wrong");
  a_pair_four: assert property (take && cmd.op == FMSC_OP_CLOSE && !cmd.bank && cmd.four_wire
    && active_mode == FMSC_WIRE_FOUR ##1 !resp.err |-> bank_two_on && bank_two_sel == $past(cmd.chan))
    else $error("four-wire partner not closed");
  a_intlk_open: assert property ((!interlock_ok_pin[0]) [*5] |-> bus_relay_on[1:0] == 2'h0)
    else $error("relay closed with interlock open");
  a_type_code: assert property (module_type_query && power_good && pg_cnt_q[1] |=> type_valid
    && type_code == (active_mode == FMSC_WIRE_ONE ? `FMSC_TYPE_SINGLE : `FMSC_TYPE_DIFF))
    else $error("type answer wrong");
  c_ov: cover property (overvolt_state);
  c_pair: cover property (bank_one_on && bank_two_on && active_mode == FMSC_WIRE_FOUR);
  c_one: cover property (type_valid && active_mode == FMSC_WIRE_ONE);
endmodule // fmsc_chk
bind fmsc_top fmsc_chk #(.CH_W(CH_W)) u_fmsc_chk (.ref_clk, .rst, .power_good, .module_type_query, .cmd_valid,
  .cmd, .interlock_ok_pin, .overvolt_pin, .resp, .type_valid, .type_code, .active_mode, .overvolt_state,
  .bank_one_sel, .bank_one_on, .bank_two_sel, .bank_two_on, .bus_relay_on);
`default_nettype wire

// *** sim/fmsc_ctrl_model.sv ***
// fmsc_ctrl_model.sv: mainframe controller model issuing commands
`timescale 1ns/1ns
`default_nettype none
module fmsc_ctrl_model (
  input  wire logic                 ref_clk,
  input  wire fmsc_pkg::fmsc_resp_t resp,
  output var  logic                 cmd_valid,
  output var  fmsc_pkg::fmsc_cmd_t  cmd,
  output var  logic                 mode_set_valid,
  output var  fmsc_pkg::fmsc_wire_t mode_set,
  output var  logic                 slot_clear_cmd,
  output var  logic                 module_type_query
);
  import fmsc_pkg::*;
  // idle outputs at time zero
  initial begin
    {cmd_valid, mode_set_valid, slot_clear_cmd, module_type_query} = 4'h0;
    cmd = '0;
    mode_set = FMSC_WIRE_TWO;
  end
  // one-cycle command; the bus is scrambled after so stale values never look valid
  task automatic send(input fmsc_op_t op, input logic bk, input logic [5:0] ch, input logic [1:0] rl,
                      input logic fw, output fmsc_resp_t r);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, bk, ch, rl, fw};
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd <= fmsc_cmd_t'(~cmd);
    #1 r = resp;
  endtask
  // one-cycle slot clear, type query or mode change
  task automatic ctl(input logic [1:0] which, input fmsc_wire_t m);
    @(posedge ref_clk);
    if (which == 2'h0) slot_clear_cmd <= 1'b1;
    else if (which == 2'h1) module_type_query <= 1'b1;
    else begin
      mode_set_valid <= 1'b1;
      mode_set <= m;
    end
    @(posedge ref_clk);
    {slot_clear_cmd, module_type_query, mode_set_valid} <= 3'h0;
    #1;
  endtask
endmodule // fmsc_ctrl_model
`default_nettype wire

// *** sim/tb_top.sv ***
// tb_top.sv: self-checking bench for the switch control block
`timescale 1ns/1ns
`default_nettype none
`include "fmsc_cfg.svh"
module tb_top;
  import fmsc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic power_good = 1'b1;
  logic global_reset_cmd = 1'b0;
  logic four_wire_ohms_measure = 1'b0;
  logic [1:0] interlock_ok_pin = 2'h3;
  logic overvolt_pin = 1'b0;
  logic cmd_valid, mode_set_valid, slot_clear_cmd, module_type_query, type_valid, overvolt_state;
  logic bank_one_on, bank_two_on;
  fmsc_cmd_t cmd;
  fmsc_wire_t mode_set, active_mode;
  fmsc_resp_t resp, r;
  logic [7:0] type_code;
  logic [5:0] bank_one_sel, bank_two_sel;
  logic [3:0] bus_relay_on;
  logic [13:0] sw;
  int error_cnt = 0;
  int check_count = 0;
  fmsc_top u_fmsc_top (.ref_clk, .rst, .clk_en, .power_good, .global_reset_cmd, .slot_clear_cmd,
    .module_type_query, .four_wire_ohms_measure, .mode_set_valid, .mode_set, .cmd_valid, .cmd,
    .interlock_ok_pin, .overvolt_pin, .resp, .type_valid, .type_code, .active_mode, .overvolt_state,
    .bank_one_sel, .bank_one_on, .bank_two_sel, .bank_two_on, .bus_relay_on);
  fmsc_ctrl_model u_fmsc_ctrl_model (.ref_clk, .resp, .cmd_valid, .cmd, .mode_set_valid, .mode_set,
    .slot_clear_cmd, .module_type_query);
  always #5 ref_clk = ~ref_clk;
  // a selection only counts while its switch is on
  assign sw = {bank_one_on, bank_one_on ? bank_one_sel : 6'h0, bank_two_on, bank_two_on ? bank_two_sel : 6'h0};
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic c(input fmsc_op_t op, input logic bk, input logic [5:0] ch, input logic [1:0] rl,
                   input logic fw, input logic er);
    u_fmsc_ctrl_model.send(op, bk, ch, rl, fw, r);
    chk({18'h0, r}, {18'h0, 1'b1, er}, "response");
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_close;
    c(FMSC_OP_CLOSE, 1'b0, 6'h03, 2'h0, 1'b0, 1'b0);
    c(FMSC_OP_CLOSE, 1'b0, 6'h13, 2'h0, 1'b0, 1'b0);
    c(FMSC_OP_CLOSE, 1'b1, 6'h00, 2'h0, 1'b0, 1'b0);
    chk(sw, {1'b1, 6'h13, 1'b1, 6'h00}, "two banks");
    c(FMSC_OP_CLOSE, 1'b0, 6'h14, 2'h0, 1'b0, 1'b1);
    c(FMSC_OP_OPEN, 1'b0, 6'h00, 2'h0, 1'b0, 1'b0);
    chk(sw, {7'h0, 1'b1, 6'h00}, "bank one open");
  endtask
  task automatic t_four;
    u_fmsc_ctrl_model.ctl(2'h2, FMSC_WIRE_FOUR);
    c(FMSC_OP_OPEN_ALL, 1'b0, 6'h00, 2'h0, 1'b0, 1'b0);
    c(FMSC_OP_CLOSE, 1'b0, 6'h05, 2'h0, 1'b1, 1'b0);
    chk(sw, {1'b1, 6'h05, 1'b1, 6'h05}, "paired");
    c(FMSC_OP_OPEN_ALL, 1'b0, 6'h00, 2'h0, 1'b0, 1'b0);
    c(FMSC_OP_CLOSE, 1'b0, 6'h06, 2'h0, 1'b0, 1'b0);
    chk(sw, {1'b1, 6'h06, 7'h0}, "not paired");
    @(posedge ref_clk);
    four_wire_ohms_measure <= 1'b1;
    c(FMSC_OP_CLOSE, 1'b0, 6'h07, 2'h0, 1'b0, 1'b0);
    chk(sw, {1'b1, 6'h07, 1'b1, 6'h07}, "measure pair");
    @(posedge ref_clk);
    four_wire_ohms_measure <= 1'b0;
  endtask
  task automatic t_mode_one;
    u_fmsc_ctrl_model.ctl(2'h1, FMSC_WIRE_TWO);
    chk({type_valid, type_code}, {1'b1, `FMSC_TYPE_DIFF}, "type diff");
    u_fmsc_ctrl_model.ctl(2'h2, FMSC_WIRE_ONE);
    chk(active_mode, FMSC_WIRE_FOUR, "mode pending");
    @(posedge ref_clk);
    power_good <= 1'b0;
    tick(5);
    chk({sw, bus_relay_on}, 20'h0, "power off");
    power_good <= 1'b1;
    tick(4);
    chk(active_mode, FMSC_WIRE_ONE, "mode applied");
    u_fmsc_ctrl_model.ctl(2'h1, FMSC_WIRE_TWO);
    chk({type_valid, type_code}, {1'b1, `FMSC_TYPE_SINGLE}, "type single");
    c(FMSC_OP_CLOSE, 1'b0, 6'h27, 2'h0, 1'b0, 1'b0);
    chk(sw, {1'b1, 6'h27, 7'h0}, "ch 39");
    c(FMSC_OP_CLOSE, 1'b1, 6'h28, 2'h0, 1'b0, 1'b1);
    @(posedge ref_clk);
    global_reset_cmd <= 1'b1;
    @(posedge ref_clk);
    global_reset_cmd <= 1'b0;
    #1 chk({active_mode, sw}, {FMSC_WIRE_TWO, 14'h0}, "global reset");
  endtask
  task automatic t_intlk;
    c(FMSC_OP_REL_CLS, 1'b0, 6'h00, 2'h0, 1'b0, 1'b0);
    c(FMSC_OP_REL_CLS, 1'b0, 6'h00, 2'h3, 1'b0, 1'b0);
    chk(bus_relay_on, 4'h9, "relays");
    interlock_ok_pin <= 2'h2;
    tick(5);
    chk(bus_relay_on, 4'h8, "interlock");
    c(FMSC_OP_REL_CLS, 1'b0, 6'h00, 2'h1, 1'b0, 1'b1);
    interlock_ok_pin <= 2'h3;
    tick(3);
    c(FMSC_OP_REL_OPN, 1'b0, 6'h00, 2'h3, 1'b0, 1'b0);
    chk(bus_relay_on, 4'h0, "relay open");
  endtask
  task automatic t_ov;
    c(FMSC_OP_CLOSE, 1'b1, 6'h04, 2'h0, 1'b0, 1'b0);
    c(FMSC_OP_REL_CLS, 1'b0, 6'h00, 2'h0, 1'b0, 1'b0);
    overvolt_pin <= 1'b1;
    tick(5);
    chk({overvolt_state, sw, bus_relay_on}, {1'b1, 18'h0}, "ov opens");
    c(FMSC_OP_CLOSE, 1'b0, 6'h02, 2'h0, 1'b0, 1'b1);
    c(FMSC_OP_REL_CLS, 1'b0, 6'h00, 2'h2, 1'b0, 1'b1);
    u_fmsc_ctrl_model.ctl(2'h0, FMSC_WIRE_TWO);
    tick(3);
    chk(overvolt_state, 1'b1, "ov persists");
    overvolt_pin <= 1'b0;
    tick(3);
    u_fmsc_ctrl_model.ctl(2'h0, FMSC_WIRE_TWO);
    chk(overvolt_state, 1'b0, "slot clear");
    c(FMSC_OP_CLOSE, 1'b0, 6'h02, 2'h0, 1'b0, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence; power is sensed two edges after reset ends
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    tick(3);
    t_close();
    t_four();
    t_mode_one();
    t_intlk();
    t_ov();
    results();
  end
  // watchdog: the sequence needs a few hundred cycles at most
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    results();
  end
endmodule // tb_top
`default_nettype wire
